// file: common/cell_cluster_pkg.sv
`default_nettype none
package cell_cluster_pkg;
    // ---------------------------------------------------------------
    // geometry and register port
    // ---------------------------------------------------------------
    localparam int CELLS  = 8;
    localparam int LUT_W  = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CFG_W  = 8;
    // ---------------------------------------------------------------
    // offsets
    // ---------------------------------------------------------------
    localparam logic [ADDR_W-1:0] LUT_BASE  = 8'h00;
    localparam logic [ADDR_W-1:0] CFG_BASE  = 8'h20;
    localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h40;
    localparam logic [ADDR_W-1:0] PIN_ADDR  = 8'h44;
    // ---------------------------------------------------------------
    // cell configuration fields
    // ---------------------------------------------------------------
    localparam int CFG_MODE_LSB   = 0;
    localparam int CFG_FF_LSB     = 2;
    localparam int CFG_BYPASS     = 4;
    localparam int CFG_CARRY_SEL  = 5;
    localparam int CFG_CASC_OR    = 6;
    localparam int CFG_CASC_START = 7;
    localparam int PIN_OUT_REG    = 0;
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [LUT_W-1:0] LUT_RST = 16'h0000;
    localparam logic [CFG_W-1:0] CFG_RST = 8'h90;
    localparam logic             PIN_RST = 1'h0;
    // ---------------------------------------------------------------
    // modes and flip-flop kinds
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_NORMAL = 4'b0001,
        MODE_ARITH  = 4'b0010,
        MODE_UPDN   = 4'b0100,
        MODE_CLRCNT = 4'b1000
    } mode_type;
    typedef enum logic [1:0] {
        FF_D  = 2'h0,
        FF_T  = 2'h1,
        FF_JK = 2'h2,
        FF_SR = 2'h3
    } ff_type;
    function automatic mode_type mode_of(input logic [1:0] code);
        case (code)
            2'h1:    mode_of = MODE_ARITH;
            2'h2:    mode_of = MODE_UPDN;
            2'h3:    mode_of = MODE_CLRCNT;
            default: mode_of = MODE_NORMAL;
        endcase
    endfunction : mode_of
endpackage : cell_cluster_pkg
`default_nettype wire

// file: hw/cell_cluster.sv
`timescale 1ns/100ps
`default_nettype none
module cell_cluster (
    // clock and reset
    input  wire logic                                   clock,
    input  wire logic                                   arst_n,
    // register port
    input  wire logic [cell_cluster_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [cell_cluster_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                                   reg_wr,
    input  wire logic                                   reg_rd,
    output logic      [cell_cluster_pkg::DATA_W-1:0]    reg_rdata_q,
    // cell data, four per cell
    input  wire logic [4*cell_cluster_pkg::CELLS-1:0]   cell_data,
    // chain links
    input  wire logic                                   carry_in,
    input  wire logic                                   cascade_in,
    output logic                                        carry_out_q,
    output logic                                        cascade_out_q,
    // shared cluster controls
    input  wire logic                                   ctrl_clock_en,
    input  wire logic                                   ctrl_clear_n,
    input  wire logic                                   ctrl_preset_n,
    // cell outputs
    output logic      [cell_cluster_pkg::CELLS-1:0]     cell_output_q,
    // pin cell
    input  wire logic                                   pin_in,
    output logic                                        pin_out_q,
    output logic                                        pin_oe_q,
    output logic                                        pin_data_q
);
    import cell_cluster_pkg::*;

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // ---------------------------------------------------------------
    // configuration store
    // ---------------------------------------------------------------
    logic [LUT_W-1:0]  lut_q [CELLS];
    logic [LUT_W-1:0]  lut_d [CELLS];
    logic [CFG_W-1:0]  cfg_q [CELLS];
    logic [CFG_W-1:0]  cfg_d [CELLS];
    logic              pin_cfg_q;
    logic              pin_cfg_d;
    logic [DATA_W-1:0] rdata_d;
    logic [CELLS-1:0]  ff_q;
    logic [CELLS-1:0]  out_w;
    logic [CELLS-1:0]  comb_w;
    logic [CELLS:0]    carry_w;
    logic [CELLS:0]    casc_w;
    logic              word_ok;
    logic [2:0]        sel;

    always_comb begin
        word_ok   = (reg_addr[1:0] == 2'h0);
        sel       = reg_addr[4:2];
        lut_d     = lut_q;
        cfg_d     = cfg_q;
        pin_cfg_d = pin_cfg_q;
        rdata_d   = '0;
        if (reg_wr && word_ok) begin
            if (reg_addr[7:5] == LUT_BASE[7:5]) begin
                lut_d[sel] = reg_wdata[LUT_W-1:0];
            end else if (reg_addr[7:5] == CFG_BASE[7:5]) begin
                cfg_d[sel] = reg_wdata[CFG_W-1:0];
            end else if (reg_addr == PIN_ADDR) begin
                pin_cfg_d = reg_wdata[PIN_OUT_REG];
            end
        end
        if (reg_rd && word_ok) begin
            if (reg_addr[7:5] == LUT_BASE[7:5]) begin
                rdata_d[LUT_W-1:0] = lut_q[sel];
            end else if (reg_addr[7:5] == CFG_BASE[7:5]) begin
                rdata_d[CFG_W-1:0] = cfg_q[sel];
            end else if (reg_addr == STAT_ADDR) begin
                rdata_d[2*CELLS:0] = {pin_data_q, ff_q, cell_output_q};
            end else if (reg_addr == PIN_ADDR) begin
                rdata_d[PIN_OUT_REG] = pin_cfg_q;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < CELLS; k++) begin
                lut_q[k] <= LUT_RST;
                cfg_q[k] <= CFG_RST;
            end
            pin_cfg_q   <= PIN_RST;
            reg_rdata_q <= '0;
        end else begin
            lut_q       <= lut_d;
            cfg_q       <= cfg_d;
            pin_cfg_q   <= pin_cfg_d;
            reg_rdata_q <= rdata_d;
        end
    end

    // ---------------------------------------------------------------
    // logic cells
    // ---------------------------------------------------------------
    // links bypass any local routing: straight cell to cell
    assign carry_w[0] = carry_in;
    assign casc_w[0]  = cascade_in;

    for (genvar i = 0; i < CELLS; i++) begin : g_cell
        mode_type   mode;
        ff_type     kind;
        logic [3:0] d;
        logic [3:0] idx;
        logic       cin;
        logic       casc;
        logic       lut;
        logic       cout;
        logic       comb;
        logic       ff_d;
        logic       out_d;
        always_comb begin
            d    = cell_data[4*i +: 4];
            mode = mode_of(cfg_q[i][CFG_MODE_LSB +: 2]);
            kind = ff_type'(cfg_q[i][CFG_FF_LSB +: 2]);
            cin  = carry_w[i];
            // identity: 1 for AND, 0 for OR
            casc = cfg_q[i][CFG_CASC_START] ? ~cfg_q[i][CFG_CASC_OR] : casc_w[i];
            case (mode)
                MODE_NORMAL: idx = {cfg_q[i][CFG_CARRY_SEL] ? cin : d[3], d[2:0]};
                MODE_ARITH:  idx = {1'b0, cin, d[1:0]};
                MODE_UPDN:   idx = {1'b0, cin, ff_q[i], d[0]};
                MODE_CLRCNT: idx = {1'b0, cin, ff_q[i], d[0]};
                default:     idx = d;
            endcase
            lut  = lut_q[i][idx];
            // upper table half forms the carry in arithmetic and counting modes
            cout = (mode == MODE_NORMAL) ? cin : lut_q[i][{1'b1, idx[2:0]}];
            // OR is AND with inverted inputs and output
            comb = cfg_q[i][CFG_CASC_OR] ? ~(~lut & ~casc) : (lut & casc);
            ff_d = ff_q[i];
            if (!ctrl_clear_n) begin
                ff_d = 1'b0;
            end else if (!ctrl_preset_n) begin
                ff_d = 1'b1;
            end else if (ctrl_clock_en) begin
                case (kind)
                    FF_D:    ff_d = comb;
                    FF_T:    ff_d = ff_q[i] ^ comb;
                    FF_JK:   ff_d = comb ? (~d[3] | ~ff_q[i]) : (~d[3] & ff_q[i]);
                    FF_SR:   ff_d = comb | (~d[3] & ff_q[i]);
                    default: ff_d = ff_q[i];
                endcase
            end
            out_d = cfg_q[i][CFG_BYPASS] ? comb : ff_q[i];
        end
        assign carry_w[i+1] = cout;
        assign casc_w[i+1]  = comb;
        assign comb_w[i]    = comb;
        assign out_w[i]     = out_d;
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                ff_q[i]          <= 1'b0;
                cell_output_q[i] <= 1'b0;
            end else begin
                ff_q[i]          <= ff_d;
                cell_output_q[i] <= out_d;
            end
        end
    end

    // ---------------------------------------------------------------
    // chain ends and pin cell
    // ---------------------------------------------------------------
    logic pin_out_d;
    logic pin_oe_d;
    logic pin_data_d;
    always_comb begin
        pin_out_d  = pin_out_q;
        pin_data_d = pin_data_q;
        pin_oe_d   = pin_cfg_q;
        // a separate flop for each direction; the unused one holds its value
        if (pin_cfg_q) begin
            pin_out_d = out_w[0];
        end else begin
            pin_data_d = pin_in;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            carry_out_q   <= 1'b0;
            cascade_out_q <= 1'b0;
            pin_out_q     <= 1'b0;
            pin_oe_q      <= 1'b0;
            pin_data_q    <= 1'b0;
        end else begin
            carry_out_q   <= carry_w[CELLS];
            cascade_out_q <= casc_w[CELLS];
            pin_out_q     <= pin_out_d;
            pin_oe_q      <= pin_oe_d;
            pin_data_q    <= pin_data_d;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_read;
        reg_rd && word_ok && reg_addr == STAT_ADDR;
    endsequence
    sequence s_stat_answer;
        reg_rdata_q[2*CELLS:0] == $past({pin_data_q, ff_q, cell_output_q});
    endsequence

    chk_stat_read: assert property (s_read |=> s_stat_answer)
        else $error("status read data wrong");
    chk_bypass_out: assert property (cfg_q[0][CFG_BYPASS] |=> cell_output_q[0] == $past(comb_w[0]))
        else $error("bypassed output not combinational result");
    chk_reg_out: assert property (!cfg_q[0][CFG_BYPASS] |=> cell_output_q[0] == $past(ff_q[0]))
        else $error("registered output not Q");
    chk_clear_low: assert property (!ctrl_clear_n |=> ff_q == '0)
        else $error("clear did not empty registers");
    chk_preset_low: assert property (ctrl_clear_n && !ctrl_preset_n |=> ff_q == '1)
        else $error("preset did not fill registers");
    chk_hold_idle: assert property (ctrl_clear_n && ctrl_preset_n && !ctrl_clock_en |=> $stable(ff_q))
        else $error("register moved without enable");
    chk_d_load: assert property (ctrl_clear_n && ctrl_preset_n && ctrl_clock_en
        && cfg_q[2][CFG_FF_LSB +: 2] == FF_D |=> ff_q[2] == $past(comb_w[2]))
        else $error("D load wrong");
    chk_t_toggle: assert property (ctrl_clear_n && ctrl_preset_n && ctrl_clock_en && comb_w[0]
        && cfg_q[0][CFG_FF_LSB +: 2] == FF_T |=> ff_q[0] != $past(ff_q[0]))
        else $error("T did not toggle");
    chk_chain_start: assert property (cfg_q[0][CFG_CASC_START] && !cfg_q[0][CFG_CASC_OR]
        |-> comb_w[0] == g_cell[0].lut)
        else $error("chain start altered result");
    chk_carry_fwd: assert property (cfg_q[4][CFG_MODE_LSB +: 2] == 2'h0 |-> carry_w[5] == carry_w[4])
        else $error("normal carry not forwarded");
    chk_cascade_end: assert property (1'b1 |=> cascade_out_q == $past(casc_w[CELLS]))
        else $error("cascade out lost");
endmodule : cell_cluster
`default_nettype wire

// file: sim/chain_neighbour.sv
`timescale 1ns/100ps
`default_nettype none
module chain_neighbour (
    // clock
    input  wire logic clock,
    // values the lower cell is asked to produce
    input  wire logic carry_req,
    input  wire logic casc_req,
    // links into the cluster
    output logic      carry_q,
    output logic      casc_q
);
    // ---------------------------------------------------------------
    // lower-order cell
    // ---------------------------------------------------------------
    // a real neighbour has a cell delay, so links move only at edges
    initial begin
        carry_q = 1'b0;
        casc_q  = 1'b0;
    end
    always @(posedge clock) begin
        carry_q <= carry_req;
        casc_q  <= casc_req;
    end
endmodule : chain_neighbour
`default_nettype wire

// file: sim/programmable_logic_cell_normal_mode_tb.sv
`timescale 1ns/100ps
`default_nettype none
module programmable_logic_cell_normal_mode_tb;
    import cell_cluster_pkg::*;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic              clock, arst_n, reg_wr, reg_rd, carry_in, cascade_in;
    logic [7:0]        reg_addr;
    logic [31:0]       reg_wdata, reg_rdata_q, cell_data, add_d;
    logic              carry_out_q, cascade_out_q, ctrl_clock_en;
    logic              ctrl_clear_n, ctrl_preset_n, pin_in;
    logic [7:0]        cell_output_q, e;
    logic              pin_out_q, pin_oe_q, pin_data_q, carry_req, casc_req;
    logic [7:0]        st [15] = '{8'h2f, 8'h07, 8'h0e, 8'h05, 8'h20, 8'h6f, 8'h4f,
                                   8'h6e, 8'haf, 8'h9e, 8'hbf, 8'h8f, 8'hde, 8'hff,
                                   8'hcf};
    logic [8:0]        ops [3] = '{9'h0ff, 9'h15a, 9'h180};
    logic [7:0]        opb [3] = '{8'h01, 8'h33, 8'h80};
    int                mismatches, tests_run;

    cell_cluster u_cell_cluster (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata_q, .cell_data, .carry_in, .cascade_in, .carry_out_q, .cascade_out_q,
        .ctrl_clock_en, .ctrl_clear_n, .ctrl_preset_n, .cell_output_q, .pin_in,
        .pin_out_q, .pin_oe_q, .pin_data_q);
    chain_neighbour u_chain_neighbour (.clock, .carry_req, .casc_req,
        .carry_q(carry_in), .casc_q(cascade_in));
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic look(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : look
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        chk("reg_rdata_q", exp, reg_rdata_q);
    endtask : rd
    task automatic cfg_all(input logic [15:0] lut, input logic [7:0] cfg);
        for (int k = 0; k < CELLS; k++) begin
            wr(LUT_BASE + 8'(4*k), {16'h0, lut});
            wr(CFG_BASE + 8'(4*k), {24'h0, cfg});
        end
    endtask : cfg_all
    // inputs land at an edge; the neighbour and the output stage add one edge each
    task automatic drive(input logic [31:0] d, input logic c, input logic s);
        @(posedge clock);
        cell_data <= d;
        carry_req <= c;
        casc_req  <= s;
        look(3);
    endtask : drive
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    // ---------------------------------------------------------------
    // clock and sequence
    // ---------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata, cell_data} = '0;
        {carry_req, casc_req, ctrl_clock_en, pin_in} = '0;
        {ctrl_clear_n, ctrl_preset_n} = 2'b11;
        mismatches = 0;
        tests_run = 0;
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd(LUT_BASE + 8'h1c, 32'h0);
        rd(CFG_BASE + 8'h1c, {24'h0, CFG_RST});
        rd(PIN_ADDR, 32'h0);
        rd(8'h80, 32'h0);
        rd(CFG_BASE + 8'h01, 32'h0);
        // every cell sees its own index, combinational path
        cfg_all(16'h6996, 8'h90);
        for (int i = 0; i < 16; i++) begin
            for (int k = 0; k < CELLS; k++)
                e[k] = ^4'(i + k); // table 6996 is the parity of its index
            drive({4'(i+7), 4'(i+6), 4'(i+5), 4'(i+4), 4'(i+3), 4'(i+2), 4'(i+1), 4'(i)}, 0, 0);
            chk("cell_output_q", {24'h0, e}, {24'h0, cell_output_q});
        end
        // table input 3 taken from carry-in instead of the fourth data input
        cfg_all(16'hff00, 8'hb0);
        drive({CELLS{4'h7}}, 1, 0);
        chk("cell_output_q", 32'hff, {24'h0, cell_output_q});
        chk("carry_out_q", 32'h1, {31'h0, carry_out_q});
        drive({CELLS{4'hf}}, 0, 0);
        chk("cell_output_q", 32'h0, {24'h0, cell_output_q});
        // AND chain, then OR chain; cell 5 decides when its data drop to 0
        for (int m = 0; m < 2; m++) begin
            cfg_all(m ? 16'h0000 : 16'hffff, m ? 8'h50 : 8'h10);
            wr(LUT_BASE + 8'h14, m ? 32'h1 : 32'hfffe);
            drive({CELLS{4'h1}}, 0, 1);
            chk("cascade_out_q", 32'h1, {31'h0, cascade_out_q});
            drive({CELLS{4'h1}}, 0, 0);
            chk("cascade_out_q", 32'h0, {31'h0, cascade_out_q});
            drive(32'hff0fffff & {CELLS{4'h1}}, 0, !m);
            chk("cascade_out_q", 32'(m), {31'h0, cascade_out_q});
            wr(CFG_BASE, m ? 32'hd0 : 32'h90);
            drive({CELLS{4'h1}}, 0, m);
            chk("cascade_out_q", 32'(!m), {31'h0, cascade_out_q});
        end
        // flip-flop kinds, at most one enable pulse per step
        for (int s = 0; s < 15; s++) begin
            // chain start, so the cascade-in left over cannot leak into the flop input
            wr(CFG_BASE, {24'h0, 2'b10, 2'b00, st[s][7:6], 2'b00});
            wr(LUT_BASE, {16'h0, {16{st[s][5]}}});
            @(posedge clock);
            cell_data     <= {28'h0, st[s][4], 3'h0};
            ctrl_clock_en <= st[s][3];
            ctrl_clear_n  <= st[s][2];
            ctrl_preset_n <= st[s][1];
            @(posedge clock);
            {ctrl_clock_en, ctrl_clear_n, ctrl_preset_n} <= 3'b011;
            look(2);
            chk("flop output", {31'h0, st[s][0]}, {31'h0, cell_output_q[0]});
        end
        // eight-bit adder over the carry chain
        cfg_all(16'he896, 8'h91);
        for (int t = 0; t < 3; t++) begin
            for (int k = 0; k < CELLS; k++)
                add_d[4*k +: 4] = {2'b00, opb[t][k], ops[t][k]};
            drive(add_d, ops[t][8], 0);
            chk("sum", 32'(ops[t][7:0] + opb[t] + ops[t][8]),
                {23'h0, carry_out_q, cell_output_q});
        end
        // shared clear empties every flop; counter modes then index by cin, Q, d0
        @(posedge clock);
        ctrl_clear_n <= 1'b0;
        @(posedge clock);
        ctrl_clear_n <= 1'b1;
        for (int m = 2; m < 4; m++) begin
            cfg_all(16'h00f0, 8'h90 | 8'(m));
            drive(32'h0, 1, 0);
            chk("cell_output_q", 32'h1, {24'h0, cell_output_q});
            chk("carry_out_q", 32'h0, {31'h0, carry_out_q});
        end
        // pin cell as input register, then as output register
        @(posedge clock);
        pin_in <= 1'b1;
        look(2);
        chk("pin_data_q", 32'h1, {31'h0, pin_data_q});
        chk("pin_oe_q", 32'h0, {31'h0, pin_oe_q});
        wr(PIN_ADDR, 32'h1);
        look(2);
        chk("pin_oe_q", 32'h1, {31'h0, pin_oe_q});
        chk("pin_out_q", 32'h1, {31'h0, pin_out_q});
        rd(PIN_ADDR, 32'h1);
        rd(STAT_ADDR, 32'h00010001);
        tally_and_finish();
    end
endmodule : programmable_logic_cell_normal_mode_tb
`default_nettype wire
